// File: logic/pbm_defs.vh
// register offsets, field positions, reset values for the port b override mux
`ifndef PBM_DEFS_VH
`define PBM_DEFS_VH
`define PBM_ADDR_CTRL 4'h0
`define PBM_ADDR_PORT 4'h4
`define PBM_ADDR_DIR 4'h8
`define PBM_ADDR_DINOFF 4'hC
`define PBM_CTRL_SPS 7
`define PBM_CTRL_PUD 4
`define PBM_CTRL_IVS 1
`define PBM_CTRL_IVC 0
`define PBM_CTRL_MASK 8'h93
`define PBM_CTRL_RST 8'h00
`define PBM_PORT_RST 8'h00
`define PBM_DIR_RST 8'h00
`define PBM_DINOFF_RST 8'h00
`define PBM_DIN_CH4 0
`define PBM_DIN_CH7 1
`define PBM_DIN_CH6 2
`define PBM_DIN_CH5 3
`define PBM_DIN_POS_IN_A 4
`define PBM_DINOFF_MASK 8'h1F
`endif

// File: logic/pbm_pin_cell.v
// one generic pin cell resolving the four override pairs
`timescale 1ns/10ps
`default_nettype none
module pbm_pin_cell (
  input wire pullup_override_en_i,
  input wire pullup_override_val_i,
  input wire direction_override_en_i,
  input wire direction_override_val_i,
  input wire value_override_en_i,
  input wire value_override_val_i,
  input wire input_enable_override_en_i,
  input wire input_enable_override_val_i,
  input wire pin_direction_bit_i,
  input wire pin_output_bit_i,
  input wire global_pullup_off_i,
  input wire sleep_clamp_i,
  input wire pad_in_i,
  output wire pullup_o,
  output wire drive_en_o,
  output wire drive_val_o,
  output wire din_o
);
  wire din_en;
  // pull-up: override or the classic 0,1,0 decode
  assign pullup_o = pullup_override_en_i ? pullup_override_val_i :
    (~pin_direction_bit_i & pin_output_bit_i & ~global_pullup_off_i);
  assign drive_en_o = direction_override_en_i ? direction_override_val_i : pin_direction_bit_i;
  // value only matters while the driver is on
  assign drive_val_o = drive_en_o & (value_override_en_i ? value_override_val_i : pin_output_bit_i);
  assign din_en = input_enable_override_en_i ? input_enable_override_val_i : ~sleep_clamp_i;
  // clamped input reads low, as the schmitt trigger does
  assign din_o = pad_in_i & din_en;
endmodule
`default_nettype wire

// File: logic/pbm_port_b_mux.v
// port b alternate-function override mux with wishbone control registers
//
// What this block does
// - pull-up disable kills every port pull-up
// - spi slave forces clock pin input unless pwm 0b is enabled
// - spi master: clock pin follows direction bit
// - forced clock input keeps output-bit pull-up
// - mosi pin input in slave, own bit master
// - forced mosi input pull-up from output bit
// - miso pin input in master, own bit slave
// - forced miso input pull-up from output bit
// - spi inputs gated by location and reset
// - pwm 1b drives bit 6 when enabled
// - irq2 forces bit 5 input enabled
// - irq1 forces bit 2 input enabled
// - adc channel disable bits kill digital inputs
// - one pos_in_a bit disables pins 4, 3
// - each pin feeds same-index pin-change source
// - control register bits 7,4,1,0, reset zero
// - pull-up override or direction/output/disable decode
// - driver from override or direction bit
// - input enable from override or sleep clamp
//
// Decided for this implementation: the register offsets and the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none
`include "pbm_defs.vh"
module pbm_port_b_mux (
  input wire clk_i,
  input wire rst_i,
  // classic wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [3:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // peripheral controls, same clock
  input wire spi_on_i,
  input wire spi_master_sel_i,
  input wire spi_sclk_out_i,
  input wire spi_mosi_out_i,
  input wire spi_miso_out_i,
  input wire pwm0_outb_en_i,
  input wire pwm0_out_b_i,
  input wire pwm1_outb_en_i,
  input wire pwm1_out_b_i,
  input wire ext_irq1_enabled_i,
  input wire ext_irq2_enabled_i,
  input wire sleep_clamp_i,
  // pads
  input wire [7:0] pad_in_i,
  output reg [7:0] pad_out_o,
  output reg [7:0] pad_oe_o,
  output reg [7:0] pad_pullup_o,
  // alternate digital inputs, then control register bits
  output reg spi_clock_in_o,
  output reg spi_mosi_in_o,
  output reg spi_miso_in_o,
  output reg ext_irq1_in_o,
  output reg ext_irq2_in_o,
  output reg [7:0] pin_change_src_o,
  output wire global_pullup_off_o,
  output wire spi_pin_location_sel_o,
  output wire vector_table_sel_o,
  output wire vector_change_unlock_o
);
  reg [7:0] mcu_control;
  reg [7:0] pin_output_bit;
  reg [7:0] pin_direction_bit;
  reg [7:0] din_off;
  reg [7:0] pad_meta;
  reg [7:0] pad_sync;
  wire wb_hit;
  wire global_pullup_off;
  wire sps;
  wire spi_slave_dflt;
  wire spi_master_dflt;
  wire [7:0] pullup_override_en;
  wire [7:0] pullup_override_val;
  wire [7:0] direction_override_en;
  wire [7:0] direction_override_val;
  wire [7:0] value_override_en;
  wire [7:0] value_override_val;
  wire [7:0] input_enable_override_en;
  wire [7:0] input_enable_override_val;
  wire [7:0] c_pu;
  wire [7:0] c_oe;
  wire [7:0] c_out;
  wire [7:0] c_din;

  // byte 0 carries every register; upper lanes ignored
  function [7:0] pbm_merge;
    input [7:0] old;
    input [7:0] wr;
    input [7:0] mask;
    input lane;
    begin
      pbm_merge = lane ? (wr & mask) : old;
    end
  endfunction

  assign global_pullup_off = mcu_control[`PBM_CTRL_PUD];
  assign sps = mcu_control[`PBM_CTRL_SPS];
  assign global_pullup_off_o = global_pullup_off;
  assign spi_pin_location_sel_o = sps;
  assign vector_table_sel_o = mcu_control[`PBM_CTRL_IVS];
  assign vector_change_unlock_o = mcu_control[`PBM_CTRL_IVC];
  assign wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  // writes land on the edge where the master sees ack, so both sides agree on when
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mcu_control <= `PBM_CTRL_RST;
      pin_output_bit <= `PBM_PORT_RST;
      pin_direction_bit <= `PBM_DIR_RST;
      din_off <= `PBM_DINOFF_RST;
      wb_ack_o <= 1'b0;
    end
    else
    begin
      wb_ack_o <= wb_hit;
      if (wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i)
      begin
        case (wb_adr_i)
          `PBM_ADDR_CTRL: mcu_control <= pbm_merge(mcu_control, wb_dat_i[7:0], `PBM_CTRL_MASK, wb_sel_i[0]);
          `PBM_ADDR_PORT: pin_output_bit <= pbm_merge(pin_output_bit, wb_dat_i[7:0], 8'hFF, wb_sel_i[0]);
          `PBM_ADDR_DIR: pin_direction_bit <= pbm_merge(pin_direction_bit, wb_dat_i[7:0], 8'hFF, wb_sel_i[0]);
          `PBM_ADDR_DINOFF: din_off <= pbm_merge(din_off, wb_dat_i[7:0], `PBM_DINOFF_MASK, wb_sel_i[0]);
          default: ;
        endcase
      end
    end
  end

  // read data; unmapped addresses read the synchronised pads and still ack
  always @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= 32'h00000000;
    else if (wb_hit & ~wb_we_i)
    begin
      case (wb_adr_i)
        `PBM_ADDR_CTRL: wb_dat_o <= {24'h000000, mcu_control};
        `PBM_ADDR_PORT: wb_dat_o <= {24'h000000, pin_output_bit};
        `PBM_ADDR_DIR: wb_dat_o <= {24'h000000, pin_direction_bit};
        `PBM_ADDR_DINOFF: wb_dat_o <= {24'h000000, din_off};
        default: wb_dat_o <= {24'h000000, pad_sync};
      endcase
    end
  end

  // pads are asynchronous: two flops before any use
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pad_meta <= 8'h00;
      pad_sync <= 8'h00;
    end
    else
    begin
      pad_meta <= pad_in_i;
      pad_sync <= pad_meta;
    end
  end

  // printed terms lost their bars; slave at default location is the override case
  assign spi_slave_dflt = spi_on_i & ~spi_master_sel_i & ~sps;
  assign spi_master_dflt = spi_on_i & spi_master_sel_i & ~sps;

  // bit 7: spi clock and pwm 0b
  assign pullup_override_en[7] = spi_slave_dflt;
  assign pullup_override_val[7] = pin_output_bit[7] & ~global_pullup_off;
  assign direction_override_en[7] = spi_slave_dflt | pwm0_outb_en_i;
  assign direction_override_val[7] = pwm0_outb_en_i;
  assign value_override_en[7] = spi_master_dflt | pwm0_outb_en_i;
  assign value_override_val[7] = pwm0_outb_en_i ? pwm0_out_b_i : spi_sclk_out_i;
  assign input_enable_override_en[7] = din_off[`PBM_DIN_CH4];
  assign input_enable_override_val[7] = 1'b0;
  // bit 6: pwm 1b
  assign pullup_override_en[6] = 1'b0;
  assign pullup_override_val[6] = 1'b0;
  assign direction_override_en[6] = pwm1_outb_en_i;
  assign direction_override_val[6] = 1'b1;
  assign value_override_en[6] = pwm1_outb_en_i;
  assign value_override_val[6] = pwm1_out_b_i;
  assign input_enable_override_en[6] = din_off[`PBM_DIN_CH7];
  assign input_enable_override_val[6] = 1'b0;
  // bit 5: irq2 beats the channel disable
  assign input_enable_override_en[5] = din_off[`PBM_DIN_CH6] | ext_irq2_enabled_i;
  assign input_enable_override_val[5] = ext_irq2_enabled_i;
  // bits 4, 3: shared pos_in_a disable
  assign input_enable_override_en[4] = din_off[`PBM_DIN_POS_IN_A];
  assign input_enable_override_en[3] = din_off[`PBM_DIN_POS_IN_A];
  // bit 2: irq1
  assign input_enable_override_en[2] = din_off[`PBM_DIN_CH5] | ext_irq1_enabled_i;
  assign input_enable_override_val[2] = ext_irq1_enabled_i;
  assign input_enable_override_val[4] = 1'b0;
  assign input_enable_override_val[3] = 1'b0;
  assign {pullup_override_en[5], pullup_override_val[5], direction_override_en[5], direction_override_val[5], value_override_en[5], value_override_val[5]} = 6'h00;
  assign {pullup_override_en[4], pullup_override_val[4], direction_override_en[4], direction_override_val[4], value_override_en[4], value_override_val[4]} = 6'h00;
  assign {pullup_override_en[3], pullup_override_val[3], direction_override_en[3], direction_override_val[3], value_override_en[3], value_override_val[3]} = 6'h00;
  assign {pullup_override_en[2], pullup_override_val[2], direction_override_en[2], direction_override_val[2], value_override_en[2], value_override_val[2]} = 6'h00;
  // bit 1: mosi, forced input as slave
  assign pullup_override_en[1] = spi_slave_dflt;
  assign pullup_override_val[1] = pin_output_bit[1] & ~global_pullup_off;
  assign direction_override_en[1] = spi_slave_dflt;
  assign direction_override_val[1] = 1'b0;
  assign value_override_en[1] = spi_master_dflt;
  assign value_override_val[1] = spi_mosi_out_i;
  assign input_enable_override_en[1] = 1'b0;
  assign input_enable_override_val[1] = 1'b0;
  // bit 0: miso, forced input as master
  assign pullup_override_en[0] = spi_master_dflt;
  assign pullup_override_val[0] = pin_output_bit[0] & ~global_pullup_off;
  assign direction_override_en[0] = spi_master_dflt;
  assign direction_override_val[0] = 1'b0;
  assign value_override_en[0] = spi_slave_dflt;
  assign value_override_val[0] = spi_miso_out_i;
  assign input_enable_override_en[0] = 1'b0;
  assign input_enable_override_val[0] = 1'b0;

  // one cell per pin; analog use left to software pull-up/direction setup
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1)
    begin : g_pin
      pbm_pin_cell u_cell (
        .pullup_override_en_i(pullup_override_en[gi]),
        .pullup_override_val_i(pullup_override_val[gi]),
        .direction_override_en_i(direction_override_en[gi]),
        .direction_override_val_i(direction_override_val[gi]),
        .value_override_en_i(value_override_en[gi]),
        .value_override_val_i(value_override_val[gi]),
        .input_enable_override_en_i(input_enable_override_en[gi]),
        .input_enable_override_val_i(input_enable_override_val[gi]),
        .pin_direction_bit_i(pin_direction_bit[gi]),
        .pin_output_bit_i(pin_output_bit[gi]),
        .global_pullup_off_i(global_pullup_off),
        .sleep_clamp_i(sleep_clamp_i),
        .pad_in_i(pad_sync[gi]),
        .pullup_o(c_pu[gi]),
        .drive_en_o(c_oe[gi]),
        .drive_val_o(c_out[gi]),
        .din_o(c_din[gi])
      );
    end
  endgenerate

  // registered pad controls and alternate inputs
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pad_out_o <= 8'h00;
      pad_oe_o <= 8'h00;
      pad_pullup_o <= 8'h00;
      spi_clock_in_o <= 1'b0;
      spi_mosi_in_o <= 1'b0;
      spi_miso_in_o <= 1'b0;
      ext_irq1_in_o <= 1'b0;
      ext_irq2_in_o <= 1'b0;
      pin_change_src_o <= 8'h00;
    end
    else
    begin
      pad_out_o <= c_out;
      pad_oe_o <= c_oe;
      pad_pullup_o <= c_pu & {8{~global_pullup_off}};
      spi_clock_in_o <= c_din[7] & ~sps;
      spi_mosi_in_o <= c_din[1] & ~sps;
      spi_miso_in_o <= c_din[0] & ~sps;
      ext_irq2_in_o <= c_din[5];
      ext_irq1_in_o <= c_din[2];
      pin_change_src_o <= c_din;
    end
  end
endmodule
`default_nettype wire

// File: tb/pbm_port_b_mux_assertions.sv
// checker: port-level properties of the port b override mux
`timescale 1ns/10ps
`default_nettype none
module pbm_chk (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [3:0] wb_adr_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire spi_on_i,
  input wire spi_master_sel_i,
  input wire pwm0_outb_en_i,
  input wire pwm0_out_b_i,
  input wire pwm1_outb_en_i,
  input wire pwm1_out_b_i,
  input wire [7:0] pad_out_o,
  input wire [7:0] pad_oe_o,
  input wire [7:0] pad_pullup_o,
  input wire spi_clock_in_o,
  input wire spi_mosi_in_o,
  input wire spi_miso_in_o,
  input wire global_pullup_off_o,
  input wire spi_pin_location_sel_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // spi overrides only apply on the default pin location
  wire slave = spi_on_i && !spi_master_sel_i && !spi_pin_location_sel_o;
  wire master = spi_on_i && spi_master_sel_i && !spi_pin_location_sel_o;
  a_pud_pullups: assert property (global_pullup_off_o |=> pad_pullup_o == 8'h00)
    else $error("pull-up on while disabled");
  a_slave_sclk: assert property (slave && !pwm0_outb_en_i |=> !pad_oe_o[7])
    else $error("slave clock pin driven");
  a_slave_mosi: assert property (slave |=> !pad_oe_o[1])
    else $error("slave data-in pin driven");
  a_master_miso: assert property (master |=> !pad_oe_o[0])
    else $error("master data-in pin driven");
  a_pwm0_drive: assert property (pwm0_outb_en_i |=> pad_oe_o[7] && pad_out_o[7] == $past(pwm0_out_b_i))
    else $error("pwm 0b not on pin 7");
  a_pwm1_drive: assert property (pwm1_outb_en_i |=> pad_oe_o[6] && pad_out_o[6] == $past(pwm1_out_b_i))
    else $error("pwm 1b not on pin 6");
  a_spi_gate: assert property (spi_pin_location_sel_o |=> {spi_clock_in_o, spi_mosi_in_o, spi_miso_in_o} == 3'b000)
    else $error("spi input not gated");
  a_ack_pulse: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single pulse");
  a_ctrl_rsvd: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 4'h0 |-> (wb_dat_o & 32'hFFFFFF6C) == 32'h0)
    else $error("reserved control bit set");
  cover property (slave);
  cover property (master);
  cover property (pwm0_outb_en_i && pwm1_outb_en_i);
endmodule
bind pbm_port_b_mux pbm_chk pbm_chk_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .spi_on_i(spi_on_i),
  .spi_master_sel_i(spi_master_sel_i), .pwm0_outb_en_i(pwm0_outb_en_i), .pwm0_out_b_i(pwm0_out_b_i),
  .pwm1_outb_en_i(pwm1_outb_en_i), .pwm1_out_b_i(pwm1_out_b_i), .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o),
  .pad_pullup_o(pad_pullup_o), .spi_clock_in_o(spi_clock_in_o), .spi_mosi_in_o(spi_mosi_in_o),
  .spi_miso_in_o(spi_miso_in_o), .global_pullup_off_o(global_pullup_off_o),
  .spi_pin_location_sel_o(spi_pin_location_sel_o));
`default_nettype wire

// File: tb/pbm_periph_model.sv
// peripheral-side model: spi, pwm and interrupt controls facing the mux
`timescale 1ns/10ps
`default_nettype none
module pbm_periph_model (
  input wire logic [3:0] mode_i,
  input wire logic val_i,
  output logic spi_on_o,
  output logic spi_master_sel_o,
  output logic spi_out_o,
  output logic pwm_en_o,
  output logic pwm_out_o,
  output logic irq_en_o
);
  // mode bits: spi on, master, pwm enables, interrupt enables
  assign spi_on_o = mode_i[0];
  assign spi_master_sel_o = mode_i[1];
  assign pwm_en_o = mode_i[2];
  assign irq_en_o = mode_i[3];
  // one shared level, so an override shows against set port bits
  assign spi_out_o = val_i;
  assign pwm_out_o = val_i;
endmodule
`default_nettype wire

// File: tb/tb.sv
// testbench: register access and pin override scenarios for the port b mux
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, v) compares += 1; if ((v) !== (e)) begin $display("MISMATCH %s exp %h got %h", n, e, v); err_count += 1; end
module tb;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, clamp = 0, val = 0;
  logic [3:0] adr = 4'h0, mode = 4'h0;
  logic [7:0] wd = 8'h00, pad = 8'h00, q;
  int err_count = 0, compares = 0, cycles = 0;
  wire [31:0] rdat;
  wire ack, son, smst, sout, pen, pval, ien, sck_in, mosi_in, miso_in, i1_in, i2_in, gpo, spsel, vsel, vunl;
  wire [7:0] pout, poe, ppu, pcs;
  pbm_port_b_mux pbm_port_b_mux_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i({24'h0, wd}), .wb_dat_o(rdat), .wb_ack_o(ack), .spi_on_i(son),
    .spi_master_sel_i(smst), .spi_sclk_out_i(sout), .spi_mosi_out_i(sout), .spi_miso_out_i(sout),
    .pwm0_outb_en_i(pen), .pwm0_out_b_i(pval), .pwm1_outb_en_i(pen), .pwm1_out_b_i(pval),
    .ext_irq1_enabled_i(ien), .ext_irq2_enabled_i(ien), .sleep_clamp_i(clamp), .pad_in_i(pad), .pad_out_o(pout),
    .pad_oe_o(poe), .pad_pullup_o(ppu), .spi_clock_in_o(sck_in), .spi_mosi_in_o(mosi_in), .spi_miso_in_o(miso_in),
    .ext_irq1_in_o(i1_in), .ext_irq2_in_o(i2_in), .pin_change_src_o(pcs), .global_pullup_off_o(gpo),
    .spi_pin_location_sel_o(spsel), .vector_table_sel_o(vsel), .vector_change_unlock_o(vunl));
  pbm_periph_model pbm_periph_model_i (.mode_i(mode), .val_i(val), .spi_on_o(son), .spi_master_sel_o(smst),
    .spi_out_o(sout), .pwm_en_o(pen), .pwm_out_o(pval), .irq_en_o(ien));
  always #4 clk_i = ~clk_i;
  task close_out;
    if (err_count == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // a hung handshake ends here
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 2000)
    begin
      err_count += 1;
      close_out();
    end
  end
  // classic cycle, held until ack is seen on a rising edge
  task automatic wb(input logic [3:0] a, input logic w, input logic [7:0] d);
    @(posedge clk_i);
    {cyc, stb, we, adr, wd} <= {2'b11, w, a, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat[7:0];
    {cyc, stb} <= 2'b00;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    wb(a, 1'b0, 8'h00);
    `CHK("rdata", e, q)
  endtask
  // pads need three edges, so six leaves margin
  task automatic st(input logic [3:0] m, input logic v, input logic c, input logic [7:0] p);
    @(posedge clk_i);
    {mode, val, clamp, pad} <= {m, v, c, p};
    repeat (6) @(posedge clk_i);
  endtask
  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 4; i++)
      rd(4'(i * 4), 8'h00);
    wb(4'h0, 1'b1, 8'hFF);
    rd(4'h0, 8'h93);
    `CHK("ctrlbits", 4'hF, {gpo, spsel, vsel, vunl})
    wb(4'hC, 1'b1, 8'hFF);
    rd(4'hC, 8'h1F);
    wb(4'h0, 1'b1, 8'h00); // analog pins stay inputs, pull-ups off
    st(4'h0, 1'b0, 1'b0, 8'hFF);
    rd(4'h2, 8'hFF);
    `CHK("pcs", 8'h03, pcs)
    st(4'h8, 1'b0, 1'b0, 8'hFF);
    `CHK("pcs", 8'h27, pcs)
    `CHK("irq", 2'b11, {i2_in, i1_in})
    wb(4'hC, 1'b1, 8'h00);
    st(4'h8, 1'b0, 1'b1, 8'hFF);
    `CHK("pcs", 8'h24, pcs)
    st(4'h0, 1'b0, 1'b1, 8'hFF);
    `CHK("pcs", 8'h00, pcs)
    wb(4'h4, 1'b1, 8'hFF);
    wb(4'h8, 1'b1, 8'h0F);
    st(4'h0, 1'b0, 1'b0, 8'hFF);
    `CHK("ppu", 8'hF0, ppu)
    `CHK("poe", 8'h0F, poe)
    wb(4'h4, 1'b1, 8'hA5);
    st(4'h0, 1'b0, 1'b0, 8'hFF);
    `CHK("ppu", 8'hA0, ppu)
    `CHK("pout", 8'h05, pout & poe)
    wb(4'h0, 1'b1, 8'h10);
    st(4'h0, 1'b0, 1'b0, 8'hFF);
    `CHK("ppu", 8'h00, ppu)
    wb(4'h0, 1'b1, 8'h00);
    wb(4'h4, 1'b1, 8'hFF);
    wb(4'h8, 1'b1, 8'hFF);
    st(4'h1, 1'b0, 1'b0, 8'hFF);
    `CHK("poe", 8'h7D, poe)
    `CHK("ppu", 8'h82, ppu)
    `CHK("pout0", 1'b0, pout[0])
    `CHK("spiin", 2'b11, {sck_in, mosi_in})
    wb(4'h0, 1'b1, 8'h10);
    st(4'h1, 1'b0, 1'b0, 8'hFF);
    `CHK("ppu", 8'h00, ppu)
    wb(4'h0, 1'b1, 8'h80);
    st(4'h1, 1'b0, 1'b0, 8'hFF);
    `CHK("spiin", 3'b000, {sck_in, mosi_in, miso_in})
    `CHK("poe", 8'hFF, poe)
    wb(4'h0, 1'b1, 8'h00);
    wb(4'h8, 1'b1, 8'h7F);
    st(4'h3, 1'b0, 1'b0, 8'hFF);
    `CHK("poe", 8'h7E, poe)
    `CHK("ppu", 8'h81, ppu)
    `CHK("pout1", 1'b0, pout[1])
    `CHK("misoin", 1'b1, miso_in)
    wb(4'h8, 1'b1, 8'h00);
    st(4'h4, 1'b0, 1'b0, 8'hFF);
    `CHK("poe", 8'hC0, poe)
    `CHK("pout", 2'b00, pout[7:6])
    st(4'h4, 1'b1, 1'b0, 8'hFF);
    `CHK("pout", 2'b11, pout[7:6])
    // mid-run reset must clear the control bits and every pad control
    wb(4'h0, 1'b1, 8'h93);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    `CHK("rstpad", 24'h000000, {poe, pout, ppu})
    rst_i <= 1'b0;
    rd(4'h0, 8'h00);
    `CHK("ctrlbits", 4'h0, {gpo, spsel, vsel, vunl})
    close_out();
  end
endmodule
`default_nettype wire
